// ---- pkg/memctl_cfg_pkg.sv ----
// memctl_cfg_pkg: constants and types of the memory-controller
// function configuration header.
// assumes byte offsets within a 256-byte configuration space and
// dword-wide configuration cycles with byte enables.
package memctl_cfg_pkg;

  // access port geometry
  localparam int DATA_W  = 32;
  localparam int LANES   = 4;
  localparam int INDEX_W = 6;

  // byte offsets of the header registers
  localparam logic [7:0] OFF_VENDOR     = 8'h00;
  localparam logic [7:0] OFF_DEVICE     = 8'h02;
  localparam logic [7:0] OFF_COMMAND    = 8'h04;
  localparam logic [7:0] OFF_STATUS     = 8'h06;
  localparam logic [7:0] OFF_REVISION   = 8'h08;
  localparam logic [7:0] OFF_SUB_CLASS  = 8'h0A;
  localparam logic [7:0] OFF_BASE_CLASS = 8'h0B;
  localparam logic [7:0] OFF_HEADER     = 8'h0E;
  localparam logic [7:0] OFF_SUB_VENDOR = 8'h2C;
  localparam logic [7:0] OFF_SUBSYSTEM  = 8'h2E;
  localparam logic [7:0] OFF_CAP_PTR    = 8'h34;
  localparam logic [7:0] OFF_ROW_BOUND  = 8'h40;
  localparam logic [7:0] OFF_ROW_ATTR   = 8'h50;
  localparam logic [7:0] OFF_TIMING     = 8'h60;
  localparam logic [7:0] OFF_POWER      = 8'h68;
  localparam logic [7:0] OFF_MODE       = 8'h70;
  localparam logic [7:0] OFF_THROTTLE   = 8'hA0;

  // dword indexes of the fixed words
  localparam logic [INDEX_W-1:0] IDX_IDENT  = OFF_VENDOR[7:2];
  localparam logic [INDEX_W-1:0] IDX_CMDSTS = OFF_COMMAND[7:2];
  localparam logic [INDEX_W-1:0] IDX_CLASS  = OFF_REVISION[7:2];
  localparam logic [INDEX_W-1:0] IDX_HEADER = OFF_HEADER[7:2];
  localparam logic [INDEX_W-1:0] IDX_SUBSYS = OFF_SUB_VENDOR[7:2];
  localparam logic [INDEX_W-1:0] IDX_CAP    = OFF_CAP_PTR[7:2];

  // fixed read values
  localparam logic [15:0] STATUS_VALUE     = 16'h0080;
  localparam logic [7:0]  SUB_CLASS_VALUE  = 8'h80;
  localparam logic [7:0]  BASE_CLASS_VALUE = 8'h08;
  localparam logic [7:0]  HEADER_VALUE     = 8'h00;
  localparam logic [7:0]  CAP_PTR_VALUE    = 8'h00;

  // identity defaults, values arbitrary
  localparam logic [15:0] VENDOR_ID_DEFAULT   = 16'h1D5C;
  localparam logic [15:0] DEVICE_ID_DEFAULT   = 16'h0A42;
  localparam logic [7:0]  REVISION_ID_DEFAULT = 8'h3C;

  // command word bit positions
  localparam int CMD_IO_SPACE_EN     = 0;
  localparam int CMD_MEM_SPACE_EN    = 1;
  localparam int CMD_MASTER_EN       = 2;
  localparam int CMD_SPECIAL_CYC_EN  = 3;
  localparam int CMD_WR_INVAL_EN     = 4;
  localparam int CMD_PALETTE_SNP_EN  = 5;
  localparam int CMD_PARITY_RESP_EN  = 6;
  localparam int CMD_STEPPING_EN     = 7;
  localparam int CMD_SYS_ERR_REP_EN  = 8;
  localparam int CMD_FAST_B2B_EN     = 9;
  localparam int CMD_RESERVED_LO     = 10;
  localparam logic [15:0] CMD_RESET  = 16'h0006;

  // writable memory-controller registers
  localparam int NUM_RW      = 6;
  localparam int RW_BOUND    = 0;
  localparam int RW_ATTR     = 1;
  localparam int RW_TIMING   = 2;
  localparam int RW_POWER    = 3;
  localparam int RW_MODE     = 4;
  localparam int RW_THROTTLE = 5;
  localparam logic [INDEX_W-1:0] RW_INDEX [NUM_RW] = '{
    OFF_ROW_BOUND[7:2], OFF_ROW_ATTR[7:2], OFF_TIMING[7:2],
    OFF_POWER[7:2], OFF_MODE[7:2], OFF_THROTTLE[7:2]};
  localparam logic [DATA_W-1:0] RW_RESET [NUM_RW] = '{
    32'h00000000, 32'h00007777, 32'h18004425,
    32'h00000000, 32'h00000081, 32'h00000000};
  localparam logic [LANES-1:0] RW_LANES [NUM_RW] = '{
    4'hF, 4'h3, 4'hF, 4'hF, 4'hF, 4'hF};

  // access sequencer states
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b01,
    ST_ANSWER = 2'b10
  } acc_state_type;

endpackage

// ---- rtl/cfg_rw_dword.sv ----
// cfg_rw_dword: one read/write configuration dword with byte enables.
// assumes wrEn is a one-cycle pulse from the access sequencer.
`timescale 1ns/100ps
`default_nettype none

module cfg_rw_dword
#(
  parameter logic [31:0] RESET_VAL = 32'h00000000,
  parameter logic [3:0]  LANE_MASK = 4'hF
)
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // write side
  input  wire logic        wrEn,
  input  wire logic [3:0]  byteEn,
  input  wire logic [31:0] wrData,
  // stored value
  output logic      [31:0] value
);

  logic [31:0] value_r;
  logic [31:0] value_nxt;

  // merge enabled lanes; unimplemented lanes keep their reset value
  always_comb
  begin
    value_nxt = value_r;
    for (int i = 0; i < 4; i++)
    begin
      if (wrEn && byteEn[i] && LANE_MASK[i])
        value_nxt[8*i +: 8] = wrData[8*i +: 8];
    end
  end

  // storage
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      value_r <= RESET_VAL;
    else
      value_r <= value_nxt;
  end

  assign value = value_r;

endmodule

`default_nettype wire

// ---- rtl/cfg_write_once.sv ----
// cfg_write_once: configuration dword that takes its first write only.
// assumes wrEn is a one-cycle pulse; only reset reopens it.
`timescale 1ns/100ps
`default_nettype none

module cfg_write_once
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // write side
  input  wire logic        wrEn,
  input  wire logic [3:0]  byteEn,
  input  wire logic [31:0] wrData,
  // stored value and lock
  output logic      [31:0] value,
  output logic             locked
);

  logic [31:0] value_r;
  logic [31:0] value_nxt;
  logic        locked_r;
  logic        locked_nxt;

  // first write stores enabled lanes and locks the word
  always_comb
  begin
    value_nxt  = value_r;
    locked_nxt = locked_r;
    if (wrEn && !locked_r)
    begin
      locked_nxt = 1'b1;
      for (int i = 0; i < 4; i++)
      begin
        if (byteEn[i])
          value_nxt[8*i +: 8] = wrData[8*i +: 8];
      end
    end
  end

  // storage
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      value_r  <= 32'h00000000;
      locked_r <= 1'b0;
    end
    else
    begin
      value_r  <= value_nxt;
      locked_r <= locked_nxt;
    end
  end

  assign value  = value_r;
  assign locked = locked_r;

endmodule

`default_nettype wire

// ---- rtl/memctl_function_config_header.sv ----
// memctl_function_config_header: configuration header of the
// memory-controller function, reached by configuration cycles.
// assumes the bridge delivers each configuration cycle as a one-cycle
// request with a dword index and byte enables, synchronous to clk.
`timescale 1ns/100ps
`default_nettype none

module memctl_function_config_header
#(
  parameter logic [15:0] VENDOR_ID   = memctl_cfg_pkg::VENDOR_ID_DEFAULT,
  parameter logic [15:0] DEVICE_ID   = memctl_cfg_pkg::DEVICE_ID_DEFAULT,
  parameter logic [7:0]  REVISION_ID = memctl_cfg_pkg::REVISION_ID_DEFAULT
)
(
  // clock and reset
  input  wire logic                                 clk,
  input  wire logic                                 rstn,
  // configuration cycle request
  input  wire logic                                 cfgReq,
  input  wire logic                                 cfgWrite,
  input  wire logic [memctl_cfg_pkg::INDEX_W-1:0]   cfgIndex,
  input  wire logic [memctl_cfg_pkg::LANES-1:0]     cfgByteEn,
  input  wire logic [memctl_cfg_pkg::DATA_W-1:0]    cfgWrData,
  // configuration cycle answer
  output logic                                      cfgAck,
  output logic      [memctl_cfg_pkg::DATA_W-1:0]    cfgRdData,
  // settings for the memory controller
  output logic      [31:0]                          rowBoundaries,
  output logic      [15:0]                          rowAttributes,
  output logic      [31:0]                          memTiming,
  output logic      [31:0]                          memPowerControl,
  output logic      [31:0]                          memControllerMode,
  output logic      [31:0]                          memThrottleControl,
  // subsystem identity words
  output logic      [31:0]                          subsystemIds,
  output logic                                      subsystemLocked
);

  import memctl_cfg_pkg::*;

  // access sequencer state
  acc_state_type       accState_r;
  acc_state_type       accState_nxt;
  logic [DATA_W-1:0]   rdData_r;
  logic [DATA_W-1:0]   rdData_nxt;

  // decode and read path
  logic                takeReq;
  logic                takeWrite;
  logic [15:0]         commandWord;
  logic [DATA_W-1:0]   readWord;
  logic [DATA_W-1:0]   rwValue [NUM_RW];
  logic                subsysWrEn;

  // a request is taken only while idle
  assign takeReq   = cfgReq && (accState_r == ST_IDLE);
  assign takeWrite = takeReq && cfgWrite;

  // command word: every bit hardwired, so writes have nothing to land in
  always_comb
  begin
    commandWord                     = 16'h0000;
    commandWord[15:CMD_RESERVED_LO] = '0;
    commandWord[CMD_FAST_B2B_EN]    = 1'b0;
    commandWord[CMD_SYS_ERR_REP_EN] = 1'b0;
    commandWord[CMD_STEPPING_EN]    = 1'b0;
    commandWord[CMD_PARITY_RESP_EN] = 1'b0;
    commandWord[CMD_PALETTE_SNP_EN] = 1'b0;
    commandWord[CMD_WR_INVAL_EN]    = 1'b0;
    commandWord[CMD_SPECIAL_CYC_EN] = 1'b0;
    commandWord[CMD_MASTER_EN]      = 1'b1;
    commandWord[CMD_MEM_SPACE_EN]   = 1'b1;
    commandWord[CMD_IO_SPACE_EN]    = 1'b0;
  end

  // writable memory-controller registers, one per table entry
  genvar g;
  generate
    for (g = 0; g < NUM_RW; g++)
    begin : rwRegs
      logic wrHit;

      // only a write to this dword reaches the storage
      assign wrHit = takeWrite && (cfgIndex == RW_INDEX[g]);

      cfg_rw_dword
      #(
        .RESET_VAL (RW_RESET[g]),
        .LANE_MASK (RW_LANES[g])
      )
      u_reg
      (
        .clk    (clk),
        .rstn   (rstn),
        .wrEn   (wrHit),
        .byteEn (cfgByteEn),
        .wrData (cfgWrData),
        .value  (rwValue[g])
      );
    end
  endgenerate

  // subsystem identity words keep their first write
  assign subsysWrEn = takeWrite && (cfgIndex == IDX_SUBSYS);

  cfg_write_once u_subsys
  (
    .clk    (clk),
    .rstn   (rstn),
    .wrEn   (subsysWrEn),
    .byteEn (cfgByteEn),
    .wrData (cfgWrData),
    .value  (subsystemIds),
    .locked (subsystemLocked)
  );

  // settings handed to the memory controller
  assign rowBoundaries      = rwValue[RW_BOUND];
  assign rowAttributes      = rwValue[RW_ATTR][15:0];
  assign memTiming          = rwValue[RW_TIMING];
  assign memPowerControl    = rwValue[RW_POWER];
  assign memControllerMode  = rwValue[RW_MODE];
  assign memThrottleControl = rwValue[RW_THROTTLE];

  // read multiplexer; bytes with nothing behind them read zero
  always_comb
  begin
    readWord = '0;
    case (cfgIndex)
      IDX_IDENT:
        readWord = {DEVICE_ID, VENDOR_ID};
      IDX_CMDSTS:
        readWord = {STATUS_VALUE, commandWord};
      IDX_CLASS:
        readWord = {BASE_CLASS_VALUE, SUB_CLASS_VALUE, 8'h00, REVISION_ID};
      IDX_HEADER:
        readWord = {8'h00, HEADER_VALUE, 16'h0000};
      IDX_SUBSYS:
        readWord = subsystemIds;
      IDX_CAP:
        readWord = {24'h000000, CAP_PTR_VALUE};
      default:
        readWord = '0;
    endcase
    for (int i = 0; i < NUM_RW; i++)
    begin
      if (cfgIndex == RW_INDEX[i])
        readWord = rwValue[i];
    end
  end

  // sequencer: take in idle, answer one cycle later, then idle again
  always_comb
  begin
    accState_nxt = accState_r;
    rdData_nxt   = rdData_r;
    case (accState_r)
      ST_IDLE:
      begin
        if (cfgReq)
        begin
          accState_nxt = ST_ANSWER;
          rdData_nxt   = cfgWrite ? '0 : readWord;
        end
      end
      ST_ANSWER:
      begin
        accState_nxt = ST_IDLE;
      end
      default:
      begin
        accState_nxt = ST_IDLE;
        rdData_nxt   = '0;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      accState_r <= ST_IDLE;
      rdData_r   <= '0;
    end
    else
    begin
      accState_r <= accState_nxt;
      rdData_r   <= rdData_nxt;
    end
  end

  // answer outputs
  assign cfgAck    = (accState_r == ST_ANSWER);
  assign cfgRdData = rdData_r;

endmodule

`default_nettype wire

// ---- sim/memctl_function_config_header_props.sv ----
// memctl_function_config_header_props: port checks on the config header.
// assumes a bind onto the header top with its identity parameters.
`timescale 1ns/100ps
`default_nettype none

module memctl_function_config_header_props
#(
  parameter logic [15:0] VENDOR_ID = 16'h0000,
  parameter logic [15:0] DEVICE_ID = 16'h0000
)
(
  // clock and reset
  input wire logic                               clk,
  input wire logic                               rstn,
  // request
  input wire logic                               cfgReq,
  input wire logic                               cfgWrite,
  input wire logic [memctl_cfg_pkg::INDEX_W-1:0] cfgIndex,
  input wire logic [memctl_cfg_pkg::LANES-1:0]   cfgByteEn,
  input wire logic [memctl_cfg_pkg::DATA_W-1:0]  cfgWrData,
  // answer and settings
  input wire logic                               cfgAck,
  input wire logic [memctl_cfg_pkg::DATA_W-1:0]  cfgRdData,
  input wire logic [31:0]                        rowBoundaries,
  input wire logic [15:0]                        rowAttributes
);
  import memctl_cfg_pkg::*;

  // requests taken by an idle sequencer
  logic taken;
  logic rdCmd;
  logic wrBound;
  logic wrAttr;
  assign taken = cfgReq && !cfgAck;
  assign rdCmd = taken && !cfgWrite && cfgIndex == IDX_CMDSTS;
  assign wrBound = taken && cfgWrite && cfgIndex == 6'h10;
  assign wrAttr = taken && cfgWrite && cfgIndex == 6'h14;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // answer timing, fixed words and writable fields
  a_ack_one_pulse: assert property (taken |=> cfgAck ##1 !cfgAck)
    else $error("answer pulse wrong");
  a_vendor_word: assert property (taken && !cfgWrite && cfgIndex == IDX_IDENT
    |=> cfgRdData[15:0] == VENDOR_ID) else $error("vendor word wrong");
  a_device_word: assert property (taken && !cfgWrite && cfgIndex == IDX_IDENT
    |=> cfgRdData[31:16] == DEVICE_ID) else $error("device word wrong");
  a_cmd_reserved: assert property (rdCmd |=> cfgRdData[15:10] == 6'h00)
    else $error("command reserved bits set");
  a_cmd_zero_bits: assert property (rdCmd
    |=> cfgRdData[9:3] == 7'h00 && !cfgRdData[0]) else $error("command zero bit set");
  a_cmd_one_bits: assert property (rdCmd |=> cfgRdData[2:1] == 2'h3)
    else $error("command one bit clear");
  a_bound_write: assert property (wrBound && cfgByteEn[3]
    |=> rowBoundaries[31:24] == $past(cfgWrData[31:24])) else $error("boundary byte lost");
  a_bound_keep: assert property (!wrBound |=> $stable(rowBoundaries))
    else $error("boundary changed");
  a_attr_write: assert property (wrAttr && cfgByteEn[1]
    |=> rowAttributes[15:8] == $past(cfgWrData[15:8])) else $error("attribute byte lost");
  a_attr_keep: assert property (!wrAttr |=> $stable(rowAttributes))
    else $error("attributes changed");
  a_unmapped_zero: assert property (taken && !cfgWrite && cfgIndex > 6'h1C
    && cfgIndex != 6'h28 |=> cfgRdData == 32'h00000000) else $error("unmapped read nonzero");
endmodule

`default_nettype wire

// ---- sim/test_memctl_function_config_header.sv ----
// test_memctl_function_config_header: directed bench for the header.
// assumes package, design and checker files are compiled first.
`timescale 1ns/100ps
`default_nettype none

module test_memctl_function_config_header;
  import memctl_cfg_pkg::*;

  // design ports
  logic               clk;
  logic               rstn;
  logic               cfgReq;
  logic               cfgWrite;
  logic [INDEX_W-1:0] cfgIndex;
  logic [LANES-1:0]   cfgByteEn;
  logic [DATA_W-1:0]  cfgWrData;
  logic               cfgAck;
  logic [DATA_W-1:0]  cfgRdData;
  logic [31:0]        rowBoundaries;
  logic [15:0]        rowAttributes;
  logic [31:0]        memTiming;
  logic [31:0]        memPowerControl;
  logic [31:0]        memControllerMode;
  logic [31:0]        memThrottleControl;
  logic [31:0]        subsystemIds;
  logic               subsystemLocked;
  int                 numErrors;
  int                 checks;

  memctl_function_config_header u_memctl_function_config_header (
    .clk(clk), .rstn(rstn), .cfgReq(cfgReq), .cfgWrite(cfgWrite), .cfgIndex(cfgIndex),
    .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData), .cfgAck(cfgAck), .cfgRdData(cfgRdData),
    .rowBoundaries(rowBoundaries), .rowAttributes(rowAttributes), .memTiming(memTiming),
    .memPowerControl(memPowerControl), .memControllerMode(memControllerMode),
    .memThrottleControl(memThrottleControl), .subsystemIds(subsystemIds),
    .subsystemLocked(subsystemLocked));

  // verdict and end of run
  task automatic close_out();
    if (numErrors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // one comparison
  task automatic check32(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      numErrors++;
      $display("MISMATCH %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one configuration cycle, answer checked one cycle after the take
  task automatic cfg_cycle(input logic wr, input logic [5:0] idx, input logic [3:0] be,
                           input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    cfgReq    <= 1'b1;
    cfgWrite  <= wr;
    cfgIndex  <= idx;
    cfgByteEn <= be;
    cfgWrData <= wd;
    @(posedge clk);
    cfgReq <= 1'b0;
    #1;
    check32({31'h00000000, cfgAck}, 32'h00000001);
    rd = cfgRdData;
  endtask

  task automatic rd_chk(input logic [5:0] idx, input logic [31:0] exp);
    logic [31:0] rd;
    cfg_cycle(1'b0, idx, 4'h0, 32'h00000000, rd);
    check32(rd, exp);
  endtask

  task automatic wr(input logic [5:0] idx, input logic [3:0] be, input logic [31:0] wd);
    logic [31:0] rd;
    cfg_cycle(1'b1, idx, be, wd, rd);
    check32(rd, 32'h00000000);
  endtask

  // reset values through ports and reads
  task automatic t_reset();
    logic [5:0]  idxs [7] = '{6'h03, 6'h0B, 6'h0D, 6'h18, 6'h1A, 6'h1C, 6'h28};
    logic [31:0] vals [7] = '{32'h00000000, 32'h00000000, 32'h00000000, 32'h18004425,
                              32'h00000000, 32'h00000081, 32'h00000000};
    check32(rowBoundaries, 32'h00000000);
    check32({16'h0000, rowAttributes}, 32'h00007777);
    rd_chk(6'h10, 32'h00000000);
    rd_chk(6'h14, 32'h00007777);
    rd_chk(6'h02, {8'h08, 8'h80, 8'h00, REVISION_ID_DEFAULT});
    for (int i = 0; i < 7; i++)
      rd_chk(idxs[i], vals[i]);
  endtask

  // identity words ignore writes
  task automatic t_ident();
    wr(6'h00, 4'hF, 32'hFFFFFFFF);
    rd_chk(6'h00, {DEVICE_ID_DEFAULT, VENDOR_ID_DEFAULT});
  endtask

  // command word stays hardwired under every pattern
  task automatic t_command();
    logic [15:0] pats [3] = '{16'hFFFF, 16'hFDF9, 16'h0000};
    for (int i = 0; i < 3; i++)
    begin
      wr(6'h01, 4'hF, {16'hFFFF, pats[i]});
      rd_chk(6'h01, 32'h00800006);
    end
  endtask

  // boundary bytes written one lane at a time
  task automatic t_bound();
    logic [31:0] exp;
    exp = 32'h00000000;
    for (int i = 0; i < 4; i++)
    begin
      wr(6'h10, 4'h1 << i, 32'hC3B2A190);
      exp[8*i +: 8] = 8'h90 + 8'(i) * 8'h11;
      check32(rowBoundaries, exp);
    end
    rd_chk(6'h10, 32'hC3B2A190);
  endtask

  // attribute word, upper lanes absent
  task automatic t_attr();
    wr(6'h14, 4'hF, 32'hAAAA1234);
    check32({16'h0000, rowAttributes}, 32'h00001234);
    rd_chk(6'h14, 32'h00001234);
  endtask

  // unlisted places and the header and capability dwords read zero and drop writes
  task automatic t_unmapped();
    logic [5:0] idxs [6] = '{6'h03, 6'h0D, 6'h1D, 6'h27, 6'h29, 6'h3F};
    for (int i = 0; i < 6; i++)
    begin
      wr(idxs[i], 4'hF, 32'hFFFFFFFF);
      rd_chk(idxs[i], 32'h00000000);
    end
    check32(rowBoundaries, 32'hC3B2A190);
    check32({16'h0000, rowAttributes}, 32'h00001234);
  endtask

  // settings words reset and write through; subsystem dword keeps its first write
  task automatic t_settings();
    check32(memTiming, 32'h18004425);
    check32(memPowerControl, 32'h00000000);
    check32(memControllerMode, 32'h00000081);
    check32(memThrottleControl, 32'h00000000);
    check32({31'h00000000, subsystemLocked}, 32'h00000000);
    wr(6'h18, 4'hF, 32'h0F1E2D3C);
    wr(6'h1A, 4'hF, 32'h4B5A6978);
    wr(6'h1C, 4'h3, 32'h8796A5B4);
    wr(6'h28, 4'hC, 32'hC3D2E1F0);
    check32(memTiming, 32'h0F1E2D3C);
    check32(memPowerControl, 32'h4B5A6978);
    check32(memControllerMode, 32'h0000A5B4);
    check32(memThrottleControl, 32'hC3D20000);
    rd_chk(6'h18, 32'h0F1E2D3C);
    wr(6'h0B, 4'h3, 32'h5A5AC3C3);
    check32(subsystemIds, 32'h0000C3C3);
    check32({31'h00000000, subsystemLocked}, 32'h00000001);
    wr(6'h0B, 4'hF, 32'hFFFFFFFF);
    rd_chk(6'h0B, 32'h0000C3C3);
  endtask

  // clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // main sequence
  initial
  begin
    rstn = 1'b0;
    cfgReq = 1'b0;
    cfgWrite = 1'b0;
    cfgIndex = 6'h00;
    cfgByteEn = 4'h0;
    cfgWrData = 32'h00000000;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_ident();
    t_command();
    t_bound();
    t_attr();
    t_unmapped();
    t_settings();
    close_out();
  end

  // watchdog, far beyond the hundred or so cycles needed
  initial
  begin
    #200000;
    numErrors++;
    close_out();
  end
endmodule

bind memctl_function_config_header memctl_function_config_header_props
  #(.VENDOR_ID(VENDOR_ID), .DEVICE_ID(DEVICE_ID)) u_props (
  .clk(clk), .rstn(rstn), .cfgReq(cfgReq), .cfgWrite(cfgWrite), .cfgIndex(cfgIndex),
  .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData), .cfgAck(cfgAck), .cfgRdData(cfgRdData),
  .rowBoundaries(rowBoundaries), .rowAttributes(rowAttributes));

`default_nettype wire
